//--- verilog/frps_flash_guard.sv
// Flash protection and security block with Avalon-MM register slave
`timescale 1ns/1ps

// How it works
// - Each block has a protect bit; set forbids program and erase there.
// - Secure state is security enable high and all six protect bits high.
// - CPU reads of flash stay allowed while secure.
// - Secure state blocks debug port communication and trace output.
// - Secure state rejects flash commands except the protect bit erase.
// - Protect bit erase while secure does chip erase and clears all bits.
// - Security register at 0x0010, status register at 0x0020, interrupt status and mask at 0x0030 and 0x0034; rest reserved.
// - Status register bits 21 to 16 show the six protect bits.
// - Ready bit 0 low while busy, stays low on failure, reset gives one.
// - Security enable is bit 0, resets to one, reinitialised on STOP2 exit.
// - Change needs key write then data write within 16 clocks.
// - Both unlock writes must be full 32-bit word writes.
// - Protect bits set one at a time, cleared in groups 0-3 and 4-5.
module frps_flash_guard
  import frps_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic                  stop2Release,
  input  wire logic [5:0]            protectInit,
  input  wire logic                  protectInitLoad,
  input  wire logic [15:0]           avsAddress,
  input  wire logic                  avsRead,
  input  wire logic                  avsWrite,
  input  wire logic [31:0]           avsWritedata,
  input  wire logic [3:0]            avsByteenable,
  output logic      [31:0]           avsReaddata,
  output logic                       avsWaitrequest,
  output logic      [1:0]            avsResponse,
  input  wire logic                  cmdValid,
  input  wire logic [1:0]            cmdKind,
  input  wire logic [2:0]            cmdBlock,
  input  wire logic                  cmdGroupHi,
  input  wire logic                  opDone,
  input  wire logic                  opFail,
  output logic                       opStart,
  output logic      [1:0]            opKind,
  output logic      [2:0]            opBlock,
  output logic                       opChipErase,
  input  wire logic                  cpuReadReq,
  output logic                       cpuReadAllow,
  output logic                       debugEnable,
  output logic                       traceEnable,
  output logic                       irq
);

  // ==========================================================================
  // State
  logic [5:0]           protect_r;
  logic                 secEnable_r;
  logic                 secure;
  frps_op_state_t       opState_r;
  logic [IRQ_W-1:0]     intStat_r;
  logic [IRQ_W-1:0]     intMask_r;
  logic                 keySeen_r;
  logic                 winOpen;
  logic                 fullWord;
  logic                 busWrite;
  logic                 busRead;
  logic                 secWrite;
  logic                 armKey;
  logic                 cancelKey;
  logic                 dataOk;
  logic                 respPend_r;
  logic                 cmdAccept;
  logic                 cmdReject;
  logic                 chipErase;
  logic [IRQ_W-1:0]     intSet;
  logic [IRQ_W-1:0]     intClr;
  logic [IRQ_W-1:0]     intStat_nxt;
  logic [IRQ_W-1:0]     intMask_nxt;
  logic [31:0]          rdData;
  logic                 mapped;

  assign secure    = secEnable_r && (&protect_r);
  assign fullWord  = (avsByteenable == 4'hf);
  assign busWrite  = avsWrite && respPend_r;
  assign busRead   = avsRead && respPend_r;
  assign secWrite  = busWrite && (avsAddress == SEC_CTRL_OFS);
  assign armKey    = secWrite && fullWord && (avsWritedata == UNLOCK_KEY) && !keySeen_r;
  assign dataOk    = secWrite && fullWord && winOpen && keySeen_r;
  assign cancelKey = (busWrite || busRead) && !armKey;

  // ==========================================================================
  // Bus slave: one wait cycle, answer on the following edge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      respPend_r <= 1'b0;
    end else begin
      respPend_r <= (avsRead || avsWrite) && !respPend_r;
    end
  end

  always_comb begin
    mapped = 1'b1;
    rdData = 32'h0000_0000;
    unique case (avsAddress)
      SEC_CTRL_OFS:  rdData[SEC_EN_BIT] = secEnable_r;
      PROT_STAT_OFS: begin
        rdData[PROT_LSB +: NUM_BLOCKS] = protect_r;
        rdData[READY_BIT] = (opState_r == FRPS_IDLE);
      end
      INT_STAT_OFS:  rdData[IRQ_W-1:0] = intStat_r;
      INT_MASK_OFS:  rdData[IRQ_W-1:0] = intMask_r;
      default:       mapped = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      avsWaitrequest <= 1'b1;
      avsReaddata    <= 32'h0000_0000;
      avsResponse    <= 2'h0;
    end else begin
      avsWaitrequest <= !((avsRead || avsWrite) && !respPend_r);
      avsReaddata    <= (avsRead && !respPend_r) ? rdData : 32'h0000_0000;
      avsResponse    <= ((avsRead || avsWrite) && !respPend_r && !mapped) ? 2'h2 : 2'h0;
    end
  end

  // ==========================================================================
  // Security enable unlock and rewrite
  frps_unlock_timer u_timer (
    .mclk   (mclk),
    .resetn (resetn),
    .arm    (armKey),
    .cancel (cancelKey),
    .open   (winOpen)
  );

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      keySeen_r <= 1'b0;
    end else if (armKey) begin
      keySeen_r <= 1'b1;
    end else if (cancelKey || !winOpen) begin
      keySeen_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      secEnable_r <= SEC_EN_RESET;
    end else if (stop2Release) begin
      secEnable_r <= SEC_EN_RESET;
    end else if (dataOk) begin
      secEnable_r <= avsWritedata[SEC_EN_BIT];
    end
  end

  // ==========================================================================
  // Flash command gate
  always_comb begin
    cmdAccept = 1'b0;
    cmdReject = 1'b0;
    chipErase = 1'b0;
    if (cmdValid && opState_r == FRPS_IDLE) begin
      if (secure && cmdKind != CMD_PROT_CLEAR) begin
        cmdReject = 1'b1;
      end else if (cmdKind == CMD_PROT_CLEAR) begin
        cmdAccept = 1'b1;
        chipErase = secure;
      end else if (cmdKind == CMD_PROT_SET) begin
        cmdAccept = 1'b1;
      end else if (protect_r[cmdBlock]) begin
        cmdReject = 1'b1;
      end else begin
        cmdAccept = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      opStart     <= 1'b0;
      opKind      <= CMD_PROGRAM;
      opBlock     <= 3'h0;
      opChipErase <= 1'b0;
    end else begin
      opStart     <= cmdAccept;
      opChipErase <= cmdAccept && chipErase;
      if (cmdAccept) begin
        opKind  <= cmdKind;
        opBlock <= cmdBlock;
      end
    end
  end

  // Busy while running; a failure keeps it busy until hardware reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      opState_r <= FRPS_IDLE;
    end else begin
      unique case (opState_r)
        FRPS_IDLE: if (cmdAccept) opState_r <= FRPS_BUSY;
        FRPS_BUSY: begin
          if (opFail) begin
            opState_r <= FRPS_FAIL;
          end else if (opDone) begin
            opState_r <= FRPS_IDLE;
          end
        end
        FRPS_FAIL: opState_r <= FRPS_FAIL;
        default:   opState_r <= FRPS_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Protect bits: reset value loaded from the stored state after release
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      protect_r <= 6'h00;
    end else if (protectInitLoad) begin
      protect_r <= protectInit;
    end else if (cmdAccept && cmdKind == CMD_PROT_SET && cmdBlock < 3'h6) begin
      protect_r[cmdBlock] <= 1'b1;
    end else if (cmdAccept && cmdKind == CMD_PROT_CLEAR) begin
      if (chipErase) begin
        protect_r <= 6'h00;
      end else begin
        protect_r <= protect_r & ~(cmdGroupHi ? GROUP_HI_MASK : GROUP_LO_MASK);
      end
    end
  end

  // ==========================================================================
  // Debug, trace and read gating
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      debugEnable  <= 1'b0;
      traceEnable  <= 1'b0;
      cpuReadAllow <= 1'b0;
    end else begin
      debugEnable  <= !secure;
      traceEnable  <= !secure;
      cpuReadAllow <= cpuReadReq;
    end
  end

  // ==========================================================================
  // Interrupts: write one to clear, set wins
  always_comb begin
    intSet = '0;
    intSet[IRQ_DONE]      = (opState_r == FRPS_BUSY) && opDone && !opFail;
    intSet[IRQ_FAIL]      = (opState_r == FRPS_BUSY) && opFail;
    intSet[IRQ_REJECT]    = cmdReject;
    intSet[IRQ_CHIPERASE] = cmdAccept && chipErase;
    intClr = (busWrite && avsAddress == INT_STAT_OFS) ? avsWritedata[IRQ_W-1:0] : '0;
    intStat_nxt = (intStat_r & ~intClr) | intSet;
    intMask_nxt = intMask_r;
    if (busWrite && avsAddress == INT_MASK_OFS) begin
      intMask_nxt = avsWritedata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      intStat_r <= '0;
      intMask_r <= '0;
      irq       <= 1'b0;
    end else begin
      intStat_r <= intStat_nxt;
      intMask_r <= intMask_nxt;
      irq       <= |(intStat_nxt & intMask_nxt);
    end
  end

  // ==========================================================================
  // Checks
  secure_debug_a: assert property (@(posedge mclk) disable iff (!resetn)
    secure |=> !debugEnable && !traceEnable)
    else $error("debug enabled while secure");
  reject_cmd_a: assert property (@(posedge mclk) disable iff (!resetn)
    (cmdValid && secure && opState_r == FRPS_IDLE && cmdKind != CMD_PROT_CLEAR)
    |=> !opStart)
    else $error("command not rejected while secure");
  chip_erase_a: assert property (@(posedge mclk) disable iff (!resetn)
    (cmdValid && secure && opState_r == FRPS_IDLE && cmdKind == CMD_PROT_CLEAR
     && !protectInitLoad) |=> opChipErase && protect_r == 6'h00)
    else $error("secure erase not chip erase");
  block_prot_a: assert property (@(posedge mclk) disable iff (!resetn)
    (cmdValid && !secure && opState_r == FRPS_IDLE && cmdKind == CMD_PROGRAM
     && protect_r[cmdBlock]) |=> !opStart)
    else $error("program to protected block");
  fail_sticky_a: assert property (@(posedge mclk) disable iff (!resetn)
    (opState_r == FRPS_FAIL) |=> (opState_r == FRPS_FAIL)[*3])
    else $error("failed state left");
  sec_keep_a: assert property (@(posedge mclk) disable iff (!resetn)
    (!dataOk && !stop2Release) |=> $stable(secEnable_r))
    else $error("security bit changed without unlock");
  narrow_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    (secWrite && !fullWord && !stop2Release) |=> $stable(secEnable_r))
    else $error("narrow write changed security bit");
  unlock_window_a: assert property (@(posedge mclk) disable iff (!resetn)
    armKey ##1 (!armKey)[*8] ##1 (!armKey)[*8] |=> !winOpen)
    else $error("unlock window too long");
  bus_answer_a: assert property (@(posedge mclk) disable iff (!resetn)
    ((avsRead || avsWrite) && avsWaitrequest) |-> ##[0:1] !avsWaitrequest)
    else $error("bus answer late");
  window_open_a: assert property (@(posedge mclk) disable iff (!resetn)
    armKey |=> winOpen)
    else $error("unlock window not opened");
  unlock_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    (dataOk && !stop2Release) |=> (secEnable_r == $past(avsWritedata[SEC_EN_BIT])))
    else $error("unlock data not taken");
  stop2_reinit_a: assert property (@(posedge mclk) disable iff (!resetn)
    stop2Release |=> secEnable_r)
    else $error("security bit not reinitialised");
  status_ro_a: assert property (@(posedge mclk) disable iff (!resetn)
    (busWrite && avsAddress == PROT_STAT_OFS && !protectInitLoad && !cmdAccept)
    |=> $stable(protect_r))
    else $error("status write changed protect bits");
  reject_status_a: assert property (@(posedge mclk) disable iff (!resetn)
    cmdReject |=> intStat_r[IRQ_REJECT])
    else $error("reject not flagged");
  read_allow_a: assert property (@(posedge mclk) disable iff (!resetn)
    (cpuReadReq && secure) |=> cpuReadAllow)
    else $error("cpu read blocked while secure");
  debug_open_a: assert property (@(posedge mclk) disable iff (!resetn)
    !secure |=> debugEnable && traceEnable)
    else $error("debug closed while not secure");
  op_start_busy_a: assert property (@(posedge mclk) disable iff (!resetn)
    opStart |-> (opState_r == FRPS_BUSY))
    else $error("start without busy state");
  irq_level_a: assert property (@(posedge mclk) disable iff (!resetn)
    irq == |(intStat_r & intMask_r))
    else $error("irq level mismatch");

  // ==========================================================================
  // Cover points
  unlock_c:  cover property (@(posedge mclk) disable iff (!resetn) dataOk);
  prot_set_c: cover property (@(posedge mclk) disable iff (!resetn)
    cmdAccept && cmdKind == CMD_PROT_SET);
  reject_c:  cover property (@(posedge mclk) disable iff (!resetn) cmdReject);
  erase_c:   cover property (@(posedge mclk) disable iff (!resetn) cmdAccept && chipErase);
  irq_c:     cover property (@(posedge mclk) disable iff (!resetn) irq);

endmodule

//--- common/frps_pkg.sv
// Package with register map, field layout and timing constants of the flash protection block
package frps_pkg;

  // ==========================================================================
  // Register map (byte offsets inside the window)
  localparam logic [15:0] SEC_CTRL_OFS    = 16'h0010;
  localparam logic [15:0] PROT_STAT_OFS   = 16'h0020;
  localparam logic [15:0] INT_STAT_OFS    = 16'h0030;
  localparam logic [15:0] INT_MASK_OFS    = 16'h0034;
  localparam logic [31:0] WINDOW_BASE     = 32'h41ff_f000;

  // ==========================================================================
  // Field layout
  localparam int          NUM_BLOCKS      = 6;
  localparam int          PROT_LSB        = 16;
  localparam int          READY_BIT       = 0;
  localparam int          SEC_EN_BIT      = 0;
  localparam logic [31:0] UNLOCK_KEY      = 32'ha74a_9d23;
  localparam logic        SEC_EN_RESET    = 1'b1;
  localparam logic        READY_RESET     = 1'b1;
  localparam logic [5:0]  GROUP_LO_MASK   = 6'h0f;
  localparam logic [5:0]  GROUP_HI_MASK   = 6'h30;

  // Interrupt status bits
  localparam int          IRQ_W           = 4;
  localparam int          IRQ_DONE        = 0;
  localparam int          IRQ_FAIL        = 1;
  localparam int          IRQ_REJECT      = 2;
  localparam int          IRQ_CHIPERASE   = 3;

  // ==========================================================================
  // Timing
  localparam int          UNLOCK_CLOCKS   = 16;
  localparam int          UNLOCK_CNT_W    = 5;

  // Flash command kinds delivered by the command decoder
  localparam logic [1:0]  CMD_PROGRAM     = 2'h0;
  localparam logic [1:0]  CMD_ERASE       = 2'h1;
  localparam logic [1:0]  CMD_PROT_SET    = 2'h2;
  localparam logic [1:0]  CMD_PROT_CLEAR  = 2'h3;

  typedef enum logic [2:0] {
    FRPS_IDLE = 3'b001,
    FRPS_BUSY = 3'b010,
    FRPS_FAIL = 3'b100
  } frps_op_state_t;

endpackage

//--- verilog/frps_unlock_timer.sv
// Unlock window timer for the security enable rewrite sequence
`timescale 1ns/1ps

module frps_unlock_timer
  import frps_pkg::*;
(
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic arm,
  input  wire logic cancel,
  output logic      open
);

  logic [UNLOCK_CNT_W-1:0] count_r;

  // ==========================================================================
  // Window counts down from the key write; any other access closes it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_r <= '0;
    end else if (arm) begin
      count_r <= UNLOCK_CNT_W'(UNLOCK_CLOCKS);
    end else if (cancel) begin
      count_r <= '0;
    end else if (count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  assign open = (count_r != '0);

endmodule

//--- sim/frps_flash_model.sv
// Behavioural flash engine that answers accepted operations
`timescale 1ns/1ps

module frps_flash_model
  import frps_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       opStart,
  input  wire logic       failMode,
  input  wire logic [5:0] latency,
  output logic            opDone,
  output logic            opFail
);
  // ==========================================================================
  // Engine
  logic [5:0] cnt_r;
  logic       busy_r;

  // One answer per accepted start, after a programmable latency
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_r  <= 6'h00;
      busy_r <= 1'b0;
      opDone <= 1'b0;
      opFail <= 1'b0;
    end else begin
      opDone <= 1'b0;
      opFail <= 1'b0;
      if (opStart) begin
        busy_r <= 1'b1;
        cnt_r  <= latency;
      end else if (busy_r && cnt_r == 6'h00) begin
        busy_r <= 1'b0;
        opDone <= !failMode;
        opFail <= failMode;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 6'h01;
      end
    end
  end
endmodule

//--- sim/frps_flash_guard_tb_top.sv
// Self-checking testbench of the flash protection and security block
`timescale 1ns/1ps

module frps_flash_guard_tb_top
  import frps_pkg::*;
;
  // ==========================================================================
  // Signals
  logic        mclk, resetn, stop2Release, protectInitLoad, avsRead, avsWrite;
  logic        cmdValid, cmdGroupHi, cpuReadReq, failMode, got, gotCe;
  logic        avsWaitrequest, opStart, opChipErase, cpuReadAllow, opDone, opFail;
  logic        debugEnable, traceEnable, irq;
  logic [5:0]  protectInit, engLatency;
  logic [15:0] avsAddress;
  logic [31:0] avsWritedata, avsReaddata, rd;
  logic [3:0]  avsByteenable;
  logic [1:0]  cmdKind, avsResponse, opKind, rr;
  logic [2:0]  cmdBlock, opBlock;
  int          miscompares, nCompared;

  frps_flash_guard DUT (.mclk(mclk), .resetn(resetn), .stop2Release(stop2Release),
    .protectInit(protectInit), .protectInitLoad(protectInitLoad), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .avsResponse(avsResponse), .cmdValid(cmdValid),
    .cmdKind(cmdKind), .cmdBlock(cmdBlock), .cmdGroupHi(cmdGroupHi), .opDone(opDone),
    .opFail(opFail), .opStart(opStart), .opKind(opKind), .opBlock(opBlock),
    .opChipErase(opChipErase), .cpuReadReq(cpuReadReq), .cpuReadAllow(cpuReadAllow),
    .debugEnable(debugEnable), .traceEnable(traceEnable), .irq(irq));

  frps_flash_model engine (.mclk(mclk), .resetn(resetn), .opStart(opStart),
    .failMode(failMode), .latency(engLatency), .opDone(opDone), .opFail(opFail));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge mclk);
    avsAddress    <= a;
    avsWrite      <= w;
    avsRead       <= !w;
    avsWritedata  <= d;
    avsByteenable <= be;
    do begin
      @(posedge mclk);
    end while (avsWaitrequest !== 1'b0);
    rd = avsReaddata;
    rr = avsResponse;
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
  endtask

  task automatic wr32(input logic [15:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rd32(input logic [15:0] a);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask

  task automatic set_sec(input logic v);
    wr32(SEC_CTRL_OFS, UNLOCK_KEY);
    wr32(SEC_CTRL_OFS, {31'h0, v});
  endtask

  task automatic wait_ready();
    int i;
    for (i = 0; i < 40; i++) begin
      rd32(PROT_STAT_OFS);
      if (rd[READY_BIT] === 1'b1) break;
    end
  endtask

  task automatic cmd(input logic [1:0] k, input logic [2:0] b, input logic hi);
    wait_ready();
    @(posedge mclk);
    cmdValid   <= 1'b1;
    cmdKind    <= k;
    cmdBlock   <= b;
    cmdGroupHi <= hi;
    @(posedge mclk);
    cmdValid <= 1'b0;
    got   = 1'b0;
    gotCe = 1'b0;
    repeat (3) begin
      @(posedge mclk);
      if (opStart === 1'b1) begin
        got   = 1'b1;
        gotCe = (opChipErase === 1'b1);
      end
    end
  endtask

  task automatic do_reset(input logic [5:0] init);
    resetn      <= 1'b0;
    protectInit <= init;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    protectInitLoad <= 1'b1;
    @(posedge mclk);
    protectInitLoad <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic s_reset_map();
    rd32(SEC_CTRL_OFS);
    chk("sec reset", rd, 32'h0000_0001);
    rd32(PROT_STAT_OFS);
    chk("status reset", rd, 32'h003f_0001);
    chk("debug secure", {debugEnable, traceEnable}, 2'b00);
    cpuReadReq <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("cpu read", cpuReadAllow, 1'b1);
    rd32(16'h0014);
    chk("reserved resp", rr, 2'b10);
    chk("reserved data", rd, 32'h0);
    wr32(PROT_STAT_OFS, 32'h0);
    rd32(PROT_STAT_OFS);
    chk("status ro", rd, 32'h003f_0001);
  endtask

  task automatic s_secure_cmd();
    int k;
    for (k = 0; k < 3; k++) begin
      cmd(k[1:0], 3'h1, 1'b0);
      chk("secure reject", got, 1'b0);
    end
    rd32(INT_STAT_OFS);
    chk("reject flag", rd[IRQ_REJECT], 1'b1);
    wr32(INT_MASK_OFS, 32'h0);
    repeat (2) @(posedge mclk);
    chk("irq masked", irq, 1'b0);
    wr32(INT_MASK_OFS, 32'h0000_0004);
    repeat (2) @(posedge mclk);
    chk("irq raised", irq, 1'b1);
    wr32(INT_STAT_OFS, 32'h0000_000f);
    repeat (2) @(posedge mclk);
    chk("irq cleared", irq, 1'b0);
  endtask

  task automatic s_unlock();
    bus(1'b1, SEC_CTRL_OFS, UNLOCK_KEY, 4'h3);
    wr32(SEC_CTRL_OFS, 32'h0);
    wr32(SEC_CTRL_OFS, UNLOCK_KEY);
    bus(1'b1, SEC_CTRL_OFS, 32'h0, 4'h1);
    wr32(SEC_CTRL_OFS, UNLOCK_KEY);
    rd32(PROT_STAT_OFS);
    wr32(SEC_CTRL_OFS, 32'h0);
    wr32(SEC_CTRL_OFS, UNLOCK_KEY);
    repeat (20) @(posedge mclk);
    wr32(SEC_CTRL_OFS, 32'h0);
    rd32(SEC_CTRL_OFS);
    chk("sec kept", rd, 32'h0000_0001);
    wr32(SEC_CTRL_OFS, UNLOCK_KEY);
    wr32(SEC_CTRL_OFS, 32'hffff_fffe);
    rd32(SEC_CTRL_OFS);
    chk("sec cleared", rd, 32'h0);
    repeat (2) @(posedge mclk);
    chk("debug open", {debugEnable, traceEnable}, 2'b11);
  endtask

  task automatic s_protect();
    int b;
    cmd(CMD_PROGRAM, 3'h2, 1'b0);
    chk("prog protected", got, 1'b0);
    cmd(CMD_ERASE, 3'h4, 1'b0);
    chk("erase protected", got, 1'b0);
    engLatency <= 6'h1e;
    cmd(CMD_PROT_CLEAR, 3'h0, 1'b0);
    chk("group erase", {got, gotCe, opKind}, {2'b10, CMD_PROT_CLEAR});
    rd32(PROT_STAT_OFS);
    chk("busy", rd[READY_BIT], 1'b0);
    wait_ready();
    chk("low group", rd, 32'h0030_0001);
    engLatency <= 6'h03;
    cmd(CMD_PROGRAM, 3'h2, 1'b0);
    chk("prog open", {got, opBlock}, {1'b1, 3'h2});
    for (b = 0; b < 4; b++) cmd(CMD_PROT_SET, b[2:0], 1'b0);
    wait_ready();
    chk("set each", rd, 32'h003f_0001);
    cmd(CMD_PROT_CLEAR, 3'h0, 1'b1);
    wait_ready();
    chk("high group", rd, 32'h000f_0001);
    cmd(CMD_PROT_SET, 3'h4, 1'b0);
    cmd(CMD_PROT_SET, 3'h5, 1'b0);
  endtask

  task automatic s_chip_erase();
    set_sec(1'b1);
    repeat (2) @(posedge mclk);
    chk("secure again", debugEnable, 1'b0);
    cmd(CMD_PROT_CLEAR, 3'h0, 1'b0);
    chk("chip erase", {got, gotCe}, 2'b11);
    wait_ready();
    chk("all cleared", rd, 32'h0000_0001);
  endtask

  task automatic s_fail_stop2();
    failMode <= 1'b1;
    cmd(CMD_PROGRAM, 3'h0, 1'b0);
    repeat (20) @(posedge mclk);
    rd32(PROT_STAT_OFS);
    chk("stays busy", rd, 32'h0);
    rd32(INT_STAT_OFS);
    chk("int status", rd, 32'h0000_000f);
    set_sec(1'b0);
    @(posedge mclk);
    stop2Release <= 1'b1;
    @(posedge mclk);
    stop2Release <= 1'b0;
    rd32(SEC_CTRL_OFS);
    chk("stop2 reinit", rd, 32'h0000_0001);
    failMode <= 1'b0;
    do_reset(6'h00);
    rd32(PROT_STAT_OFS);
    chk("ready reset", rd, 32'h0000_0001);
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    {resetn, stop2Release, protectInitLoad, avsRead, avsWrite, cmdValid} = 6'h00;
    {cmdGroupHi, cpuReadReq, failMode} = 3'h0;
    {protectInit, avsAddress, avsWritedata} = 54'h0;
    {cmdKind, cmdBlock} = 5'h00;
    avsByteenable = 4'hf;
    engLatency = 6'h08;
    miscompares = 0;
    nCompared = 0;
    do_reset(6'h3f);
    s_reset_map();
    s_secure_cmd();
    s_unlock();
    s_protect();
    s_chip_erase();
    s_fail_stop2();
    end_of_test();
  end

  initial begin
    #300us;
    miscompares++;
    end_of_test();
  end
endmodule
